// ### rtl/pfac_pkg.sv
// pfac_pkg: constants for the program/data flash access controller.
// assumes byte addresses into a 64 kByte program space, 12-bit data space.
package pfac_pkg;
    // ------------------------------------------------------------------
    // memory variants and sizes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFAC_MEM_62K,
        PFAC_MEM_32K,
        PFAC_MEM_8K
    } pfac_mem_type;

    localparam int unsigned PFAC_KB = 1024;
    localparam logic [15:0] PFAC_SIZE_62K = 16'(62 * PFAC_KB);
    localparam logic [15:0] PFAC_SIZE_32K = 16'(32 * PFAC_KB);
    localparam logic [15:0] PFAC_SIZE_8K  = 16'(8 * PFAC_KB);
    localparam logic [15:0] PFAC_RTP_TOP_62K = 16'(56 * PFAC_KB);
    localparam logic [15:0] PFAC_RTP_LO_32K  = 16'(24 * PFAC_KB);
    localparam logic [15:0] PFAC_KERNEL_LO = 16'(56 * PFAC_KB);
    localparam logic [15:0] PFAC_BOOT_VECTOR = 16'hE000;
    localparam logic [15:0] PFAC_RESET_VECTOR = 16'h0000;

    // ------------------------------------------------------------------
    // data flash
    // ------------------------------------------------------------------
    localparam int unsigned PFAC_DATA_BYTES = 4 * PFAC_KB;
    localparam int unsigned PFAC_DATA_AW    = 12;
    localparam int unsigned PFAC_PAGE_BYTES = 4;
    localparam logic [7:0]  PFAC_ERASED     = 8'hFF;

    // ------------------------------------------------------------------
    // programming paths and parallel operation codes on port_three
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFAC_PATH_NORMAL,
        PFAC_PATH_SERIAL,
        PFAC_PATH_PARALLEL
    } pfac_path_type;

    localparam logic [1:0] PFAC_OP_NONE  = 2'h0;
    localparam logic [1:0] PFAC_OP_PROG  = 2'h1;
    localparam logic [1:0] PFAC_OP_ERASE = 2'h2;
    localparam logic [1:0] PFAC_OP_SET   = 2'h3;
endpackage : pfac_pkg

// ### rtl/pfac_data_flash.sv
// pfac_data_flash: 4 kByte data flash, byte program, 4-byte page erase.
// assumes one request per cycle at most; results appear next cycle.
`timescale 1ns/100ps
`default_nettype none
module pfac_data_flash
    import pfac_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_prog,
    input  wire logic                    i_erase,
    input  wire logic [PFAC_DATA_AW-1:0] i_addr,
    input  wire logic [7:0]              i_wdata,
    output logic [7:0]                   o_rdata,
    output logic                         o_reject
);
    import pfac_pkg::*;

    logic [7:0] mem_r [PFAC_DATA_BYTES];
    logic [7:0] rdata_r;
    logic       reject_r;
    wire        prog_ok = i_prog && (mem_r[i_addr] == PFAC_ERASED);

    // ------------------------------------------------------------------
    // array, no reset: contents are nonvolatile
    // ------------------------------------------------------------------
    // page erase per entry
    genvar g;
    generate
        for (g = 0; g < PFAC_DATA_BYTES; g++) begin : g_byte
            always_ff @(posedge i_clk) begin
                if (i_erase && (i_addr[PFAC_DATA_AW-1:2] == g / 4)) begin
                    mem_r[g] <= PFAC_ERASED;
                end else if (prog_ok && (i_addr == g)) begin
                    mem_r[g] <= mem_r[g] & i_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r  <= 8'h00;
            reject_r <= 1'b0;
        end else begin
            rdata_r  <= mem_r[i_addr];
            reject_r <= i_prog && !prog_ok;
        end
    end

    assign o_rdata  = rdata_r;
    assign o_reject = reject_r;
endmodule : pfac_data_flash
`default_nettype wire

// ### rtl/pfac_top.sv
// pfac_top: program flash access control and programming path select.
// assumes flash array outside; this block grants or refuses write strobes.
// Operation
// - without runtime mode, user code sees all program flash read-only
// - runtime mode lets user erase/program the lowest 56 kBytes
// - top 6 kBytes alterable only by serial or parallel paths
// - 32 kByte part: runtime region 24k..32k, kernel at 56k..62k
// - 8 kByte part has no runtime-reprogrammable region
// - data flash: byte program, 4-byte page erase, erase first
// - download_select_pin low at reset enters serial download unless parallel mode is also set
// - parallel mode: ports carry address/data, strobe writes, port_three op
// - bootload option set: start at E000H after every reset
`timescale 1ns/100ps
`default_nettype none
module pfac_top
    import pfac_pkg::*;
#(
    parameter pfac_mem_type MEM_VARIANT = PFAC_MEM_62K
)
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_download_select_pin_n,
    input  wire logic                    i_parallel_mode,
    input  wire logic                    i_runtime_reprogram_mode,
    input  wire logic                    i_user_prog,
    input  wire logic                    i_user_erase,
    input  wire logic [15:0]             i_user_addr,
    input  wire logic [7:0]              i_user_wdata,
    input  wire logic                    i_serial_prog,
    input  wire logic                    i_serial_erase,
    input  wire logic                    i_serial_set_boot,
    input  wire logic [15:0]             i_serial_addr,
    input  wire logic [7:0]              i_serial_wdata,
    input  wire logic [7:0]              i_port_zero,
    input  wire logic [7:0]              i_port_one,
    input  wire logic [7:0]              i_port_two,
    input  wire logic [1:0]              i_port_three,
    input  wire logic                    i_strobe,
    input  wire logic                    i_data_prog,
    input  wire logic                    i_data_erase,
    input  wire logic [PFAC_DATA_AW-1:0] i_data_addr,
    input  wire logic [7:0]              i_data_wdata,
    output logic [7:0]                   o_data_rdata,
    output logic                         o_data_reject,
    output pfac_path_type                o_path,
    output logic [15:0]                  o_start_addr,
    output logic                         o_boot_option,
    output logic                         o_flash_prog,
    output logic                         o_flash_erase,
    output logic [15:0]                  o_flash_addr,
    output logic [7:0]                   o_flash_wdata,
    output logic                         o_user_reject
);
    import pfac_pkg::*;

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // three stages; a change counts once stages two and three agree
    logic [2:0] psel_sync_r;
    logic [2:0] par_sync_r;
    logic [2:0] stb_sync_r;
    logic       psel_r;
    logic       par_r;
    logic       stb_r;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            psel_sync_r <= 3'h7;
            par_sync_r  <= 3'h0;
            stb_sync_r  <= 3'h0;
            psel_r      <= 1'b1;
            par_r       <= 1'b0;
            stb_r       <= 1'b0;
        end else begin
            psel_sync_r <= {psel_sync_r[1:0], i_download_select_pin_n};
            par_sync_r  <= {par_sync_r[1:0], i_parallel_mode};
            stb_sync_r  <= {stb_sync_r[1:0], i_strobe};
            if (psel_sync_r[1] == psel_sync_r[2]) psel_r <= psel_sync_r[2];
            if (par_sync_r[1] == par_sync_r[2]) par_r <= par_sync_r[2];
            if (stb_sync_r[1] == stb_sync_r[2]) stb_r <= stb_sync_r[2];
        end
    end

    // ------------------------------------------------------------------
    // path selection, caught once after reset release
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_SAMPLE,
        ST_RUN
    } pfac_state_type;

    pfac_state_type state_r;
    pfac_path_type  path_r;
    logic [1:0]     settle_r;
    // option lives in nonvolatile fuse; survives core reset, not power
    logic           boot_opt_r = 1'b0;
    logic [15:0]    start_r;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= ST_SETTLE;
            settle_r <= 2'h0;
            path_r   <= PFAC_PATH_NORMAL;
            start_r  <= PFAC_RESET_VECTOR;
        end else begin
            case (state_r)
                // wait for the filtered pins to fill
                ST_SETTLE: begin
                    settle_r <= settle_r + 2'h1;
                    if (settle_r == 2'h3) state_r <= ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    state_r <= ST_RUN;
                    if (par_r) begin
                        path_r <= PFAC_PATH_PARALLEL;
                    end else if (!psel_r) begin
                        path_r <= PFAC_PATH_SERIAL;
                    end else begin
                        path_r <= PFAC_PATH_NORMAL;
                    end
                    start_r <= boot_opt_r ? PFAC_BOOT_VECTOR
                                          : PFAC_RESET_VECTOR;
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_SETTLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------------
    logic [15:0] ul_lo;
    logic [15:0] ul_hi;
    assign ul_lo = (MEM_VARIANT == PFAC_MEM_32K) ? PFAC_RTP_LO_32K
                                                 : 16'h0000;
    assign ul_hi = (MEM_VARIANT == PFAC_MEM_62K) ? PFAC_RTP_TOP_62K :
                   (MEM_VARIANT == PFAC_MEM_32K) ? PFAC_SIZE_32K : 16'h0000;

    wire in_ul_region = (i_user_addr >= ul_lo) && (i_user_addr < ul_hi);
    wire in_kernel    = (i_user_addr >= PFAC_KERNEL_LO);
    wire user_req     = i_user_prog || i_user_erase;
    wire user_ok = i_runtime_reprogram_mode && in_ul_region && !in_kernel
                   && (path_r == PFAC_PATH_NORMAL) && (state_r == ST_RUN);

    logic stb_d_r;
    wire  par_go  = (path_r == PFAC_PATH_PARALLEL) && stb_r && !stb_d_r;
    wire  ser_act = (path_r == PFAC_PATH_SERIAL);
    wire  par_op_prog  = par_go && (i_port_three == PFAC_OP_PROG);
    wire  par_op_erase = par_go && (i_port_three == PFAC_OP_ERASE);
    wire  par_op_set   = par_go && (i_port_three == PFAC_OP_SET);

    // ------------------------------------------------------------------
    // flash strobes
    // ------------------------------------------------------------------
    logic        fprog_r;
    logic        ferase_r;
    logic        rej_r;
    logic [15:0] faddr_r;
    logic [7:0]  fwdata_r;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            stb_d_r  <= 1'b0;
            fprog_r  <= 1'b0;
            ferase_r <= 1'b0;
            rej_r    <= 1'b0;
            faddr_r  <= 16'h0000;
            fwdata_r <= 8'h00;
        end else begin
            stb_d_r <= stb_r;
            // refusal reported whichever path owns the strobes
            rej_r   <= user_req && !user_ok;
            // parallel path has priority over serial and user
            if (par_op_prog || par_op_erase) begin
                fprog_r  <= par_op_prog;
                ferase_r <= par_op_erase;
                faddr_r  <= {i_port_two, i_port_one};
                fwdata_r <= i_port_zero;
            end else if (ser_act && (i_serial_prog || i_serial_erase)) begin
                fprog_r  <= i_serial_prog;
                ferase_r <= i_serial_erase;
                faddr_r  <= i_serial_addr;
                fwdata_r <= i_serial_wdata;
            end else begin
                fprog_r  <= i_user_prog && user_ok;
                ferase_r <= i_user_erase && user_ok;
                faddr_r  <= i_user_addr;
                fwdata_r <= i_user_wdata;
            end
        end
    end

    // option kept across every reset, set only by download paths
    always_ff @(posedge i_clk) begin
        if ((ser_act && i_serial_set_boot) || par_op_set) begin
            boot_opt_r <= 1'b1;
        end
    end

    pfac_data_flash u_data (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_prog  (i_data_prog),
        .i_erase (i_data_erase),
        .i_addr  (i_data_addr),
        .i_wdata (i_data_wdata),
        .o_rdata (o_data_rdata),
        .o_reject(o_data_reject)
    );

    assign o_path        = path_r;
    assign o_start_addr  = start_r;
    assign o_boot_option = boot_opt_r;
    assign o_flash_prog  = fprog_r;
    assign o_flash_erase = ferase_r;
    assign o_flash_addr  = faddr_r;
    assign o_flash_wdata = fwdata_r;
    assign o_user_reject = rej_r;
endmodule : pfac_top
`default_nettype wire

// ### tb/pfac_top_props.sv
// pfac_top_props: port checks for the access controller.
// assumes requests only after the pins have settled.
`timescale 1ns/100ps
`default_nettype none
module pfac_top_props
    import pfac_pkg::*;
#(
    parameter pfac_mem_type MEM_VARIANT = PFAC_MEM_62K
)
(
    input wire logic          i_clk,
    input wire logic          i_rst_n,
    input wire logic          i_runtime_reprogram_mode,
    input wire logic          i_user_prog,
    input wire logic          i_user_erase,
    input wire logic [15:0]   i_user_addr,
    input wire logic [7:0]    i_user_wdata,
    input wire logic          i_data_prog,
    input wire pfac_path_type o_path,
    input wire logic          o_boot_option,
    input wire logic          o_flash_prog,
    input wire logic          o_flash_erase,
    input wire logic [15:0]   o_flash_addr,
    input wire logic [7:0]    o_flash_wdata,
    input wire logic          o_data_reject,
    input wire logic          o_user_reject
);
    import pfac_pkg::*;
    logic       req;
    logic       in_win;
    logic       nrm;
    logic [3:0] age_r;
    assign req = i_user_prog | i_user_erase;
    assign nrm = (o_path == PFAC_PATH_NORMAL);
    assign in_win = (MEM_VARIANT == PFAC_MEM_62K) ?
        (i_user_addr < PFAC_RTP_TOP_62K) : (MEM_VARIANT == PFAC_MEM_32K) ?
        (i_user_addr >= PFAC_RTP_LO_32K && i_user_addr < PFAC_SIZE_32K) :
        1'b0;
    // path only trusted once the pin filters have settled
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) age_r <= 4'h0;
        else if (age_r != 4'hF) age_r <= age_r + 4'h1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_ok_req;
        req && in_win && i_runtime_reprogram_mode && nrm;
    endsequence
    sequence s_bad_req;
        req && nrm && (!in_win || !i_runtime_reprogram_mode);
    endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_grant_strobe: assert property (s_ok_req |=> o_flash_prog ==
        $past(i_user_prog) && o_flash_erase == $past(i_user_erase)
        && !o_user_reject) else $error("granted request lost");
    a_grant_addr: assert property (s_ok_req |=>
        o_flash_addr == $past(i_user_addr)
        && o_flash_wdata == $past(i_user_wdata)) else $error("grant addr");
    a_refuse_user: assert property (s_bad_req |=> o_user_reject
        && !o_flash_prog && !o_flash_erase) else $error("not refused");
    a_kernel_guard: assert property (req && nrm && i_user_addr >=
        PFAC_BOOT_VECTOR |=> !o_flash_prog && !o_flash_erase)
        else $error("kernel altered by user");
    a_no_stray: assert property ((o_flash_prog || o_flash_erase)
        && nrm |-> $past(req)) else $error("write without request");
    a_boot_sticky: assert property (o_boot_option |=> o_boot_option)
        else $error("boot option dropped");
    a_path_steady: assert property (age_r >= 4'hC |-> $stable(o_path))
        else $error("path moved");
    a_data_reject: assert property (o_data_reject |-> $past(i_data_prog))
        else $error("reject without program");
endmodule : pfac_top_props
bind pfac_top pfac_top_props #(.MEM_VARIANT(MEM_VARIANT)) u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_user_prog(i_user_prog),
    .i_runtime_reprogram_mode(i_runtime_reprogram_mode),
    .i_user_erase(i_user_erase), .i_user_addr(i_user_addr),
    .i_user_wdata(i_user_wdata), .i_data_prog(i_data_prog),
    .o_path(o_path), .o_boot_option(o_boot_option),
    .o_flash_prog(o_flash_prog), .o_flash_erase(o_flash_erase),
    .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata),
    .o_data_reject(o_data_reject), .o_user_reject(o_user_reject));
`default_nettype wire

// ### tb/pfac_prog_model.sv
// pfac_prog_model: parallel programmer on the port bus.
// assumes one operation at a time, started by a go pulse.
`timescale 1ns/100ps
`default_nettype none
module pfac_prog_model
    import pfac_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_go,
    input  wire logic [1:0]  i_op,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_data,
    output logic [7:0]       o_port_zero,
    output logic [7:0]       o_port_one,
    output logic [7:0]       o_port_two,
    output logic [1:0]       o_port_three,
    output logic             o_strobe,
    output logic             o_busy
);
    logic [3:0] step_r;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) step_r <= 4'h0;
        else if (i_go || step_r != 4'h0) step_r <= step_r + 4'h1;
    end
    // ports held well around a strobe
    assign o_busy = (step_r != 4'h0);
    assign o_strobe = (step_r >= 4'h4) && (step_r <= 4'h8);
    // released bus shows inverted data, never a stale copy
    assign {o_port_two, o_port_one, o_port_zero} =
        o_busy ? {i_addr, i_data} : ~{i_addr, i_data};
    assign o_port_three = o_busy ? i_op : PFAC_OP_NONE;
endmodule : pfac_prog_model
`default_nettype wire

// ### tb/test_pfac_top.sv
// test_pfac_top: self-checking bench for the access controller.
// assumes the 62 kByte variant and the parallel programmer model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module test_pfac_top;
    import pfac_pkg::*;
    logic clk, rst_n, dsel_n, par, mode, u_prog, u_erase, s_prog, s_erase;
    logic s_boot, strobe, d_prog, d_erase, d_rej, go, busy, boot;
    logic f_prog, f_erase, u_rej;
    logic [15:0] u_addr, s_addr, f_addr, start, p_addr;
    logic [7:0] u_wd, s_wd, d_wd, d_rd, f_wd, p0, p1, p2, p_data;
    logic [11:0] d_addr;
    logic [1:0] p3, p_op;
    pfac_path_type path;
    int errors = 0, n_checks = 0, cyc = 0;
    pfac_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_download_select_pin_n(dsel_n),
        .i_parallel_mode(par), .i_runtime_reprogram_mode(mode),
        .i_user_prog(u_prog), .i_user_erase(u_erase), .i_user_addr(u_addr),
        .i_user_wdata(u_wd), .i_serial_prog(s_prog), .i_serial_erase(s_erase),
        .i_serial_set_boot(s_boot), .i_serial_addr(s_addr),
        .i_serial_wdata(s_wd), .i_port_zero(p0), .i_port_one(p1),
        .i_port_two(p2), .i_port_three(p3), .i_strobe(strobe),
        .i_data_prog(d_prog), .i_data_erase(d_erase), .i_data_addr(d_addr),
        .i_data_wdata(d_wd), .o_data_rdata(d_rd), .o_data_reject(d_rej),
        .o_path(path), .o_start_addr(start), .o_boot_option(boot),
        .o_flash_prog(f_prog), .o_flash_erase(f_erase), .o_flash_addr(f_addr),
        .o_flash_wdata(f_wd), .o_user_reject(u_rej));
    pfac_prog_model prog (.i_clk(clk), .i_rst_n(rst_n), .i_go(go),
        .i_op(p_op), .i_addr(p_addr), .i_data(p_data), .o_port_zero(p0),
        .o_port_one(p1), .o_port_two(p2), .o_port_three(p3),
        .o_strobe(strobe), .o_busy(busy));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    // hang guard, far above the whole sequence
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic reset_dut(input logic dn, input logic pm, pfac_path_type ep,
                             logic eb);
        @(posedge clk) rst_n <= 0;
        dsel_n <= dn;
        par <= pm;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        repeat (13) @(posedge clk);
        #1 `CHK("path", ep, path)
        `CHK("start", eb ? PFAC_BOOT_VECTOR : PFAC_RESET_VECTOR, start)
        `CHK("boot", eb, boot)
    endtask : reset_dut
    task automatic user_req(input logic pr, er, input logic [15:0] a, ok);
        @(posedge clk) {u_prog, u_erase, u_addr, u_wd} <= {pr, er, a, ~a[7:0]};
        @(posedge clk) {u_prog, u_erase} <= 2'b00;
        #1 `CHK("flash_prog", pr & ok, f_prog)
        `CHK("flash_erase", er & ok, f_erase)
        `CHK("user_reject", !ok, u_rej)
        if (ok) `CHK("flash_addr", a, f_addr)
    endtask : user_req
    task automatic ser_req(input logic pr, er, sb, input logic [15:0] a);
        @(posedge clk) {s_prog, s_erase, s_boot, s_addr} <= {pr, er, sb, a};
        {u_prog, u_addr} <= {1'b1, 16'h0040};
        @(posedge clk) {s_prog, s_erase, s_boot, u_prog} <= 4'h0;
        #1 `CHK("ser_prog", pr, f_prog)
        `CHK("ser_erase", er, f_erase)
        `CHK("ser_user_rej", 1'b1, u_rej)
        if (pr | er) `CHK("ser_addr", a, f_addr)
    endtask : ser_req
    task automatic par_op(input logic [1:0] op, input logic [15:0] a);
        int k;
        @(posedge clk) {go, p_op, p_addr, p_data} <= {1'b1, op, a, a[15:8]};
        @(posedge clk) go <= 0;
        k = 0;
        while (f_prog !== 1'b1 && f_erase !== 1'b1 && k < 30) begin
            @(posedge clk) #1 k++;
        end
        `CHK("par_prog", op == PFAC_OP_PROG, f_prog)
        `CHK("par_erase", op == PFAC_OP_ERASE, f_erase)
        if (op != PFAC_OP_SET) `CHK("par_addr", a, f_addr)
        if (op == PFAC_OP_PROG) `CHK("par_data", a[15:8], f_wd)
        while (busy) @(posedge clk);
    endtask : par_op
    task automatic data_op(input logic pr, er, input logic [11:0] a,
                           input logic [7:0] d, rj, eb);
        @(posedge clk) {d_prog, d_erase, d_addr, d_wd} <= {pr, er, a, d};
        @(posedge clk) {d_prog, d_erase} <= 2'b00;
        #1 `CHK("data_reject", rj, d_rej)
        @(posedge clk) #1 `CHK("data_byte", eb, d_rd)
    endtask : data_op
    initial begin
        {rst_n, dsel_n, par, mode, u_prog, u_erase, s_prog, s_erase} = 8'h40;
        {s_boot, d_prog, d_erase, go, u_addr, s_addr, p_addr} = 'h0;
        {u_wd, s_wd, d_wd, p_data, d_addr, p_op} = 'h0;
        s_wd = 8'hC3;
        reset_dut(1'b1, 1'b0, PFAC_PATH_NORMAL, 1'b0);
        user_req(1'b1, 1'b0, 16'h0100, 1'b0);
        mode <= 1'b1;
        user_req(1'b1, 1'b0, 16'h0000, 1'b1);
        user_req(1'b0, 1'b1, 16'hDFFF, 1'b1);
        user_req(1'b1, 1'b0, 16'hE000, 1'b0);
        user_req(1'b0, 1'b1, 16'hF7FF, 1'b0);
        user_req(1'b1, 1'b0, 16'hF800, 1'b0);
        data_op(1'b0, 1'b1, 12'h014, 8'h00, 1'b0, 8'hFF);
        data_op(1'b1, 1'b0, 12'h014, 8'h11, 1'b0, 8'h11);
        data_op(1'b0, 1'b1, 12'h010, 8'h00, 1'b0, 8'hFF);
        data_op(1'b1, 1'b0, 12'h012, 8'hA5, 1'b0, 8'hA5);
        data_op(1'b1, 1'b0, 12'h012, 8'h0F, 1'b1, 8'hA5);
        data_op(1'b0, 1'b1, 12'h013, 8'h00, 1'b0, 8'hFF);
        data_op(1'b0, 1'b0, 12'h012, 8'h00, 1'b0, 8'hFF);
        data_op(1'b0, 1'b0, 12'h014, 8'h00, 1'b0, 8'h11);
        reset_dut(1'b0, 1'b0, PFAC_PATH_SERIAL, 1'b0);
        ser_req(1'b1, 1'b0, 1'b0, 16'hF000);
        ser_req(1'b0, 1'b1, 1'b0, 16'hE100);
        ser_req(1'b0, 1'b0, 1'b1, 16'h0000);
        @(posedge clk) #1 `CHK("boot_set", 1'b1, boot)
        reset_dut(1'b1, 1'b1, PFAC_PATH_PARALLEL, 1'b1);
        par_op(PFAC_OP_PROG, 16'hF85A);
        par_op(PFAC_OP_ERASE, 16'hE000);
        par_op(PFAC_OP_SET, 16'h0000);
        `CHK("par_boot", 1'b1, boot)
        end_sim();
    end
endmodule : test_pfac_top
`default_nettype wire
